// File: core/hsq_homing_sequencer.sv
// hsq_homing_sequencer: homing sequencer with its dictionary objects
// assumes a 200 MHz ref_clk, position loop and current loop on the same
// clock, and limit and index pins asynchronous to it
`timescale 1ns/1ps
`default_nettype none
`include "hsq_regs.svh"
module hsq_homing_sequencer #(
  parameter int MS_CYCLES = `HSQ_MS_CYCLES,
  parameter int DELAY_WIDTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire hsq_pkg::hsq_obj_req_s objReq,
  output logic [31:0] objRdData,
  output logic objRdValid,
  input wire logic posLimitPin,
  input wire logic negLimitPin,
  input wire logic indexPin,
  input wire logic atCurrentLimit,
  input wire logic [DELAY_WIDTH-1:0] hardStopDelayMs,
  input wire logic signed [31:0] homeOffset,
  input wire logic signed [31:0] actualPos,
  input wire logic trajDone,
  output hsq_pkg::hsq_traj_s traj,
  output logic signed [31:0] zeroPos,
  output logic zeroValid
);

  // dictionary objects
  logic [15:0] controlCommandWord;
  logic [7:0] operatingModeSelect;
  logic [7:0] homingMethodSelect;
  logic [31:0] homingSpeedPair;
  logic [31:0] homingAccelRate;

  // sequencer state
  hsq_pkg::hsq_state_e state;
  hsq_pkg::hsq_state_e next_state;
  logic dirPos;
  logic next_dirPos;
  logic slow;
  logic next_slow;
  logic captureHome;
  logic homeAttained;
  logic homeError;
  logic moveArmed;
  logic startPrev;
  logic idxPrev;
  logic [DELAY_WIDTH-1:0] hsCount;

  // synchronised pins and tick
  logic [2:0] pinSync;
  logic msTick;

  hsq_sync #(.WIDTH(3)) pinSyncInst (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .asyncIn({indexPin, negLimitPin, posLimitPin}),
    .syncOut(pinSync)
  );

  hsq_tick #(.CYCLES(MS_CYCLES)) msTickInst (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tick(msTick)
  );

  // pin and control decoding
  wire posLim = pinSync[0];
  wire negLim = pinSync[1];
  wire idxLevel = pinSync[2];
  wire idxRise = idxLevel & ~idxPrev;
  wire homingMode = (operatingModeSelect == `HSQ_OPMODE_HOMING);
  wire startBit = controlCommandWord[`HSQ_CW_START_BIT];
  wire startRise = startBit & ~startPrev;
  wire run = homingMode & startBit;
  wire [15:0] fastSpd = homingSpeedPair[`HSQ_SPD_FAST_LSB +: `HSQ_SPD_WIDTH];
  wire [15:0] slowSpd = homingSpeedPair[`HSQ_SPD_SLOW_LSB +: `HSQ_SPD_WIDTH];

  // direction and reference limit of the selected method
  wire methodPos = (homingMethodSelect == `HSQ_M_IDX_POS) ||
                   (homingMethodSelect == `HSQ_M_LIM_POS) ||
                   (homingMethodSelect == `HSQ_M_LIMIDX_POS) ||
                   (homingMethodSelect == `HSQ_M_HS_POS);
  wire limitOnly = (homingMethodSelect == `HSQ_M_LIM_POS) ||
                   (homingMethodSelect == `HSQ_M_LIM_NEG);
  wire refLimit = methodPos ? posLim : negLim;
  wire dirLimit = dirPos ? posLim : negLim;
  wire hardStop = atCurrentLimit && (hsCount >= hardStopDelayMs);

  // signed speed from magnitude and direction
  function automatic logic signed [31:0] signedSpeed(
    input logic [15:0] mag,
    input logic pos
  );
    return pos ? $signed({16'h0000, mag}) : -$signed({16'h0000, mag});
  endfunction

  // next state of the homing sequence
  always_comb begin
    next_state = state;
    next_dirPos = dirPos;
    next_slow = slow;
    captureHome = 1'b0;
    if (!run) begin
      next_state = hsq_pkg::HSQ_IDLE;
    end else begin
      case (state)
        hsq_pkg::HSQ_IDLE: begin
          if (startRise) begin
            case (homingMethodSelect)
              `HSQ_M_CURRENT: begin
                captureHome = 1'b1;
                next_state = hsq_pkg::HSQ_DONE;
              end
              `HSQ_M_CUR_ZERO: begin
                captureHome = 1'b1;
                next_state = hsq_pkg::HSQ_MOVE_ZERO;
              end
              `HSQ_M_IDX_POS, `HSQ_M_IDX_NEG: begin
                next_dirPos = methodPos;
                next_slow = 1'b1;
                next_state = hsq_pkg::HSQ_SEEK_IDX;
              end
              `HSQ_M_LIM_POS, `HSQ_M_LIM_NEG,
              `HSQ_M_LIMIDX_POS, `HSQ_M_LIMIDX_NEG: begin
                next_slow = 1'b0;
                if (refLimit) begin
                  next_dirPos = ~methodPos;
                  next_state = hsq_pkg::HSQ_AWAY;
                end else begin
                  next_dirPos = methodPos;
                  next_state = hsq_pkg::HSQ_SEEK_SW;
                end
              end
              `HSQ_M_HS_POS, `HSQ_M_HS_NEG: begin
                next_dirPos = methodPos;
                next_slow = 1'b0;
                next_state = hsq_pkg::HSQ_SEEK_HS;
              end
              default: next_state = hsq_pkg::HSQ_FAULT;
            endcase
          end
        end
        hsq_pkg::HSQ_AWAY: begin
          if (!refLimit) begin
            next_dirPos = methodPos;
            next_state = hsq_pkg::HSQ_SEEK_SW;
          end
        end
        hsq_pkg::HSQ_SEEK_SW: begin
          if (refLimit && limitOnly) begin
            captureHome = 1'b1;
            next_state = hsq_pkg::HSQ_DONE;
          end else if (refLimit) begin
            next_dirPos = ~methodPos;
            next_slow = 1'b1;
            next_state = hsq_pkg::HSQ_SEEK_IDX;
          end
        end
        hsq_pkg::HSQ_SEEK_IDX: begin
          if (idxRise) begin
            captureHome = 1'b1;
            next_state = hsq_pkg::HSQ_DONE;
          end else if (dirLimit) begin
            next_state = hsq_pkg::HSQ_FAULT;
          end
        end
        hsq_pkg::HSQ_SEEK_HS: begin
          if (dirLimit) begin
            next_state = hsq_pkg::HSQ_FAULT;
          end else if (hardStop) begin
            captureHome = 1'b1;
            next_state = hsq_pkg::HSQ_DONE;
          end
        end
        hsq_pkg::HSQ_MOVE_ZERO: begin
          if (moveArmed && trajDone) begin
            next_state = hsq_pkg::HSQ_DONE;
          end
        end
        hsq_pkg::HSQ_DONE, hsq_pkg::HSQ_FAULT: next_state = state;
        default: next_state = hsq_pkg::HSQ_IDLE;
      endcase
    end
  end

  // state, edge history and move arming
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= hsq_pkg::HSQ_IDLE;
      dirPos <= 1'b1;
      slow <= 1'b0;
      startPrev <= 1'b0;
      idxPrev <= 1'b0;
      moveArmed <= 1'b0;
    end else begin
      state <= next_state;
      dirPos <= next_dirPos;
      slow <= next_slow;
      startPrev <= startBit;
      idxPrev <= idxLevel;
      moveArmed <= (state == hsq_pkg::HSQ_MOVE_ZERO);
    end
  end

  // hard stop timer counts free running millisecond ticks at the current limit
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !atCurrentLimit || state != hsq_pkg::HSQ_SEEK_HS) begin
      hsCount <= '0;
    end else if (msTick && hsCount != '1) begin
      hsCount <= hsCount + 1'b1;
    end
  end

  // home capture and new zero: home plus offset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      zeroPos <= '0;
      zeroValid <= 1'b0;
    end else if (captureHome) begin
      zeroPos <= actualPos + homeOffset;
      zeroValid <= 1'b1;
    end
  end

  // status flags: cleared by a new start, a set in the same cycle wins
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      homeAttained <= 1'b0;
      homeError <= 1'b0;
    end else begin
      homeAttained <= (homeAttained & ~(startRise & homingMode)) |
                      (next_state == hsq_pkg::HSQ_DONE &&
                       state != hsq_pkg::HSQ_DONE);
      homeError <= (homeError & ~(startRise & homingMode)) |
                   (next_state == hsq_pkg::HSQ_FAULT &&
                    state != hsq_pkg::HSQ_FAULT);
    end
  end

  // trajectory parameters registered from the next state
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      traj <= '0;
    end else begin
      traj.accel <= homingAccelRate;
      traj.target <= captureHome ? actualPos + homeOffset : zeroPos;
      case (next_state)
        hsq_pkg::HSQ_AWAY, hsq_pkg::HSQ_SEEK_SW,
        hsq_pkg::HSQ_SEEK_IDX, hsq_pkg::HSQ_SEEK_HS: begin
          traj.mode <= hsq_pkg::HSQ_PROF_VELOCITY;
          traj.vel <= signedSpeed(next_slow ? slowSpd : fastSpd,
                                  next_dirPos);
        end
        hsq_pkg::HSQ_MOVE_ZERO: begin
          traj.mode <= hsq_pkg::HSQ_PROF_POSITION;
          traj.vel <= signedSpeed(fastSpd, 1'b1);
        end
        default: begin
          traj.mode <= hsq_pkg::HSQ_PROF_HOLD;
          traj.vel <= '0;
        end
      endcase
    end
  end

  // object writes; the status word is read only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      controlCommandWord <= `HSQ_RST_CONTROL;
      operatingModeSelect <= `HSQ_RST_OPMODE;
      homingMethodSelect <= `HSQ_RST_METHOD;
      homingSpeedPair <= `HSQ_RST_SPEEDS;
      homingAccelRate <= `HSQ_RST_ACCEL;
    end else if (objReq.wrEn) begin
      case (objReq.index)
        `HSQ_IDX_CONTROL: controlCommandWord <= objReq.wrData[15:0];
        `HSQ_IDX_OPMODE: operatingModeSelect <= objReq.wrData[7:0];
        `HSQ_IDX_METHOD: homingMethodSelect <= objReq.wrData[7:0];
        `HSQ_IDX_SPEEDS: homingSpeedPair <= objReq.wrData;
        `HSQ_IDX_ACCEL: homingAccelRate <= objReq.wrData;
        default: ;
      endcase
    end
  end

  // status word and read selection
  wire stopped = (state == hsq_pkg::HSQ_DONE) ||
                 (state == hsq_pkg::HSQ_FAULT) ||
                 (state == hsq_pkg::HSQ_IDLE);
  wire [15:0] statusWord = ({15'h0000, stopped} << `HSQ_SW_TGT_BIT) |
                           ({15'h0000, homeAttained} << `HSQ_SW_ATTAINED_BIT) |
                           ({15'h0000, homeError} << `HSQ_SW_ERROR_BIT);
  wire [31:0] readSel =
    (objReq.index == `HSQ_IDX_CONTROL) ? {16'h0000, controlCommandWord} :
    (objReq.index == `HSQ_IDX_STATUS) ? {16'h0000, statusWord} :
    (objReq.index == `HSQ_IDX_OPMODE) ? {24'h000000, operatingModeSelect} :
    (objReq.index == `HSQ_IDX_METHOD) ? {24'h000000, homingMethodSelect} :
    (objReq.index == `HSQ_IDX_SPEEDS) ? homingSpeedPair :
    (objReq.index == `HSQ_IDX_ACCEL) ? homingAccelRate :
    32'h0000_0000;

  // read answer one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      objRdData <= '0;
      objRdValid <= 1'b0;
    end else begin
      objRdValid <= objReq.rdEn;
      if (objReq.rdEn) begin
        objRdData <= readSel;
      end
    end
  end

  // checks next to the logic they guard
  idle_outside_mode_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !homingMode |=> state == hsq_pkg::HSQ_IDLE &&
                    traj.mode == hsq_pkg::HSQ_PROF_HOLD)
    else $error("sequence active outside homing mode");
  start_index_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state == hsq_pkg::HSQ_IDLE && startRise && homingMode &&
     homingMethodSelect == `HSQ_M_IDX_POS)
    |=> state == hsq_pkg::HSQ_SEEK_IDX && traj.vel == $signed({16'h0000,
        $past(slowSpd)}))
    else $error("start bit did not begin index seek");
  error_flag_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    state != hsq_pkg::HSQ_FAULT && next_state == hsq_pkg::HSQ_FAULT
    |=> homeError && state == hsq_pkg::HSQ_FAULT)
    else $error("homing error not reported");
  zero_offset_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    captureHome |=> zeroValid &&
                   zeroPos == $past(actualPos) + $past(homeOffset))
    else $error("new zero is not home plus offset");
  slow_index_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    state == hsq_pkg::HSQ_SEEK_IDX && $stable(homingSpeedPair)
    |-> traj.vel == signedSpeed(slowSpd, dirPos))
    else $error("index seek not at slow speed");
  accel_single_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    traj.mode != hsq_pkg::HSQ_PROF_HOLD
    |-> traj.accel == $past(homingAccelRate))
    else $error("homing acceleration not applied");
  method_zero_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (state == hsq_pkg::HSQ_IDLE && startRise && homingMode &&
     homingMethodSelect == `HSQ_M_CURRENT)
    |=> state == hsq_pkg::HSQ_DONE && traj.vel == 32'sh0000_0000 &&
        traj.mode == hsq_pkg::HSQ_PROF_HOLD)
    else $error("method zero moved the axis");
  move_zero_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    state == hsq_pkg::HSQ_MOVE_ZERO
    |-> traj.mode == hsq_pkg::HSQ_PROF_POSITION && traj.target == zeroPos)
    else $error("final move not aimed at new zero");
  index_limit_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    state == hsq_pkg::HSQ_SEEK_IDX && run && dirPos && posLim && !idxRise
    |=> state == hsq_pkg::HSQ_FAULT ##1 homeError)
    else $error("limit before index not flagged");
  hard_stop_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    state == hsq_pkg::HSQ_SEEK_HS && run && !dirLimit && atCurrentLimit &&
    hsCount >= hardStopDelayMs |=> state == hsq_pkg::HSQ_DONE)
    else $error("hard stop not detected");

endmodule // hsq_homing_sequencer
`default_nettype wire

// File: core/hsq_regs.svh
// hsq_regs.svh: object indices, field positions, reset values and timing
// counts for the homing sequencer; assumes a 200 MHz ref_clk
`ifndef HSQ_REGS_SVH
`define HSQ_REGS_SVH

// object dictionary indices
`define HSQ_IDX_CONTROL 16'h6040
`define HSQ_IDX_STATUS 16'h6041
`define HSQ_IDX_OPMODE 16'h6060
`define HSQ_IDX_METHOD 16'h6098
`define HSQ_IDX_SPEEDS 16'h6099
`define HSQ_IDX_ACCEL 16'h609a

// reset values
`define HSQ_RST_CONTROL 16'h0000
`define HSQ_RST_OPMODE 8'h00
`define HSQ_RST_METHOD 8'h00
`define HSQ_RST_SPEEDS 32'h0000_0000
`define HSQ_RST_ACCEL 32'h0000_0000

// field positions
`define HSQ_OPMODE_HOMING 8'h06
`define HSQ_CW_START_BIT 4
`define HSQ_SW_TGT_BIT 10
`define HSQ_SW_ATTAINED_BIT 12
`define HSQ_SW_ERROR_BIT 13
`define HSQ_SPD_FAST_LSB 0
`define HSQ_SPD_SLOW_LSB 16
`define HSQ_SPD_WIDTH 16

// homing method codes (signed 8 bit)
`define HSQ_M_CURRENT 8'h00
`define HSQ_M_CUR_ZERO 8'h23
`define HSQ_M_IDX_POS 8'h22
`define HSQ_M_IDX_NEG 8'h21
`define HSQ_M_LIM_POS 8'h12
`define HSQ_M_LIM_NEG 8'h11
`define HSQ_M_LIMIDX_POS 8'h02
`define HSQ_M_LIMIDX_NEG 8'h01
`define HSQ_M_HS_POS 8'hff
`define HSQ_M_HS_NEG 8'hfe

// timing: one millisecond tick for the hard stop delay
`define HSQ_CLK_PERIOD_NS 5
`define HSQ_MS_TIME_NS 1000000
`define HSQ_MS_CYCLES (`HSQ_MS_TIME_NS / `HSQ_CLK_PERIOD_NS)

`endif

// File: core/hsq_pkg.sv
// hsq_pkg: types shared by the homing sequencer files
// assumes nothing beyond a SystemVerilog compiler
package hsq_pkg;

  // profile kind handed to the position loop
  typedef enum logic [1:0] {
    HSQ_PROF_HOLD,
    HSQ_PROF_VELOCITY,
    HSQ_PROF_POSITION
  } hsq_prof_e;

  // trajectory parameters for the position loop
  typedef struct packed {
    hsq_prof_e mode;
    logic signed [31:0] vel;
    logic [31:0] accel;
    logic signed [31:0] target;
  } hsq_traj_s;

  // one dictionary object access
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [15:0] index;
    logic [31:0] wrData;
  } hsq_obj_req_s;

  // sequencer states
  typedef enum {
    HSQ_IDLE,
    HSQ_AWAY,
    HSQ_SEEK_SW,
    HSQ_SEEK_IDX,
    HSQ_SEEK_HS,
    HSQ_MOVE_ZERO,
    HSQ_DONE,
    HSQ_FAULT
  } hsq_state_e;

endpackage

// File: core/hsq_sync.sv
// hsq_sync: two flip-flop synchroniser for pin levels
// assumes inputs are asynchronous levels; output is one ref_clk domain level
`timescale 1ns/1ps
`default_nettype none
module hsq_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stage1 <= '0;
      syncOut <= '0;
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule // hsq_sync
`default_nettype wire

// File: core/hsq_tick.sv
// hsq_tick: divider giving a one-cycle enable every CYCLES clocks
// assumes CYCLES is at least 2
`timescale 1ns/1ps
`default_nettype none
module hsq_tick #(
  parameter int CYCLES = 200000
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  output logic tick
);
  localparam int CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] count;

  // free running count, pulse on wrap
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      count <= (count == LAST) ? '0 : count + 1'b1;
      tick <= (count == LAST);
    end
  end
endmodule // hsq_tick
`default_nettype wire

// File: tb/hsq_axis_model.sv
// hsq_axis_model: behavioural motor axis with limits, index and hard stops
// assumes traj from the sequencer on ref_clk; loadEn presets the position
`timescale 1ns/1ps
`default_nettype none
module hsq_axis_model #(
  parameter int STEP_CYC = 8,
  parameter int LIMIT = 100,
  parameter int STOP = 50
) (
  input wire logic ref_clk,
  input wire hsq_pkg::hsq_traj_s traj,
  input wire logic loadEn,
  input wire logic signed [31:0] loadPos,
  input wire logic idxEn,
  input wire logic stopEn,
  output logic signed [31:0] actualPos,
  output logic trajDone,
  output logic posLimitPin,
  output logic negLimitPin,
  output logic indexPin,
  output logic atCurrentLimit
);
  logic signed [31:0] dir;
  logic signed [31:0] nextPos;
  logic blocked;
  int stepCnt;
  // direction of travel asked for by the profile
  always_comb begin
    dir = 32'sh0;
    if (traj.mode == hsq_pkg::HSQ_PROF_VELOCITY) begin
      if (traj.vel > 0) dir = 32'sh1;
      if (traj.vel < 0) dir = -32'sh1;
    end else if (traj.mode == hsq_pkg::HSQ_PROF_POSITION) begin
      if (traj.target > actualPos) dir = 32'sh1;
      if (traj.target < actualPos) dir = -32'sh1;
    end
  end
  // hard stop blocks travel and the drive sits at its current limit
  assign nextPos = actualPos + dir;
  assign blocked = stopEn && (nextPos > STOP || nextPos < -STOP);
  assign atCurrentLimit = blocked && dir != 32'sh0;
  assign trajDone = traj.mode == hsq_pkg::HSQ_PROF_POSITION && dir == 0;
  // switches active high past the ends, index every 16 counts
  assign posLimitPin = actualPos >= LIMIT;
  assign negLimitPin = actualPos <= -LIMIT;
  assign indexPin = idxEn && actualPos[3:0] == 4'h0;
  // one count every STEP_CYC clocks so pin delays do not shift home
  always_ff @(posedge ref_clk) begin
    if (loadEn) begin
      actualPos <= loadPos;
      stepCnt <= 0;
    end else if (stepCnt == STEP_CYC - 1) begin
      stepCnt <= 0;
      if (!blocked) actualPos <= nextPos;
    end else begin
      stepCnt <= stepCnt + 1;
    end
  end
endmodule // hsq_axis_model
`default_nettype wire

// File: tb/hsq_homing_sequencer_tb.sv
// hsq_homing_sequencer_tb: self-checking bench for the homing sequencer
// assumes hsq_axis_model as far side and a 1 ms tick cut to 20 clocks
`timescale 1ns/1ps
`default_nettype none
module hsq_homing_sequencer_tb;
  localparam logic [31:0] VF = 32'h0000_0100;
  localparam logic [31:0] VS = 32'h0000_0040;
  localparam logic [31:0] ACC = 32'h0000_1234;
  localparam logic [31:0] HOLD = 32'(hsq_pkg::HSQ_PROF_HOLD);
  localparam logic [31:0] POSN = 32'(hsq_pkg::HSQ_PROF_POSITION);
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic loadEn = 1'b1;
  logic idxEn = 1'b1;
  logic stopEn = 1'b0;
  logic [15:0] hardStopDelayMs = 16'h0;
  logic signed [31:0] homeOffset = 32'sh0;
  logic signed [31:0] loadPos = 32'sh0;
  hsq_pkg::hsq_obj_req_s objReq = '0;
  hsq_pkg::hsq_traj_s traj;
  logic signed [31:0] actualPos, zeroPos;
  logic [31:0] objRdData;
  logic objRdValid, zeroValid, trajDone;
  logic posLimitPin, negLimitPin, indexPin, atCurrentLimit;
  int failCount = 0;
  int cmpCount = 0;
  int cycles = 0;

  hsq_homing_sequencer #(.MS_CYCLES(20)) hsq_homing_sequencer_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .objReq(objReq),
    .objRdData(objRdData), .objRdValid(objRdValid),
    .posLimitPin(posLimitPin), .negLimitPin(negLimitPin),
    .indexPin(indexPin), .atCurrentLimit(atCurrentLimit),
    .hardStopDelayMs(hardStopDelayMs), .homeOffset(homeOffset),
    .actualPos(actualPos), .trajDone(trajDone), .traj(traj),
    .zeroPos(zeroPos), .zeroValid(zeroValid));
  hsq_axis_model hsq_axis_model_inst (
    .ref_clk(ref_clk), .traj(traj), .loadEn(loadEn), .loadPos(loadPos),
    .idxEn(idxEn), .stopEn(stopEn), .actualPos(actualPos),
    .trajDone(trajDone), .posLimitPin(posLimitPin),
    .negLimitPin(negLimitPin), .indexPin(indexPin),
    .atCurrentLimit(atCurrentLimit));

  // 200 MHz clock
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failCount++;
      finishTest();
    end
  end

  task automatic finishTest;
    $display("comparisons %0d mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    cmpCount++;
    if (got !== exp) begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // object access: request held one cycle, answer one cycle later
  task automatic objWr(input logic [15:0] idx, input logic [31:0] val);
    @(negedge ref_clk);
    objReq = '{1'b1, 1'b0, idx, val};
    @(negedge ref_clk);
    objReq = '0;
  endtask
  task automatic objRd(input logic [15:0] idx, output logic [31:0] val);
    @(negedge ref_clk);
    objReq = '{1'b0, 1'b1, idx, 32'h0};
    @(negedge ref_clk);
    objReq = '0;
    check("rdValid", 32'h1, 32'(objRdValid));
    val = objRdData;
  endtask
  // preset axis, choose method, then raise the start bit from zero
  task automatic startHoming(input logic [7:0] m, input logic [31:0] p,
                             input logic [31:0] off);
    @(negedge ref_clk);
    loadEn = 1'b1;
    loadPos = p;
    homeOffset = off;
    @(negedge ref_clk);
    loadEn = 1'b0;
    objWr(16'h6098, {24'h0, m});
    objWr(16'h6040, 32'h0);
    objWr(16'h6040, 32'h10);
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic expectEnd(input logic err, input logic [31:0] home);
    logic [31:0] sw;
    for (int i = 0; i < 4000; i++) begin
      objRd(16'h6041, sw);
      if (sw[12] === 1'b1 || sw[13] === 1'b1) break;
    end
    check("attained", {31'h0, ~err}, {31'h0, sw[12]});
    check("error", {31'h0, err}, {31'h0, sw[13]});
    if (!err) check("zeroPos", home, zeroPos);
  endtask

  task automatic testRegs;
    logic [31:0] v;
    logic [15:0] idx [6] = '{16'h6040, 16'h6060, 16'h6098, 16'h6099,
                             16'h609a, 16'h60ff};
    foreach (idx[i]) begin
      objRd(idx[i], v);
      check("resetVal", 32'h0, v);
    end
    objWr(16'h6041, 32'h0000_3000);
    objRd(16'h6041, v);
    check("statusRo", 32'h0000_0400, v);
    objWr(16'h6099, {VS[15:0], VF[15:0]});
    objWr(16'h609a, ACC);
    objWr(16'h6060, 32'h0000_0106);
    objRd(16'h6099, v);
    check("speeds", {VS[15:0], VF[15:0]}, v);
    objRd(16'h609a, v);
    check("accel", ACC, v);
    objRd(16'h6060, v);
    check("mode", 32'h6, v);
    objRd(16'h60ff, v);
    check("unmapped", 32'h0, v);
    $display("regs done");
  endtask
  task automatic testMode;
    logic [31:0] v;
    idxEn = 1'b0;
    objWr(16'h6060, 32'h0);
    startHoming(8'h22, 32'h3, 32'h0);
    check("holdOff", HOLD, 32'(traj.mode));
    objWr(16'h6060, 32'h6);
    objWr(16'h6040, 32'h0);
    objWr(16'h6040, 32'h10);
    repeat (4) @(negedge ref_clk);
    check("velSlow", VS, traj.vel);
    check("accelUsed", ACC, traj.accel);
    objWr(16'h6040, 32'h0);
    repeat (2) @(negedge ref_clk);
    check("abortHold", HOLD, 32'(traj.mode));
    objRd(16'h6041, v);
    check("abortFlags", 32'h0, v & 32'h3000);
    idxEn = 1'b1;
    $display("mode done");
  endtask
  task automatic testCurrent;
    startHoming(8'h00, 32'h25, 32'h5);
    check("noMotion", HOLD, 32'(traj.mode));
    expectEnd(1'b0, 32'h2a);
    check("stayed", 32'h25, actualPos);
    check("zeroValid", 32'h1, 32'(zeroValid));
    $display("current done");
  endtask
  task automatic testMoveZero;
    startHoming(8'h23, 32'h14, 32'hffff_fff4);
    check("posMode", POSN, 32'(traj.mode));
    check("target", 32'h8, traj.target);
    expectEnd(1'b0, 32'h8);
    check("atZero", 32'h8, actualPos);
    $display("move zero done");
  endtask
  task automatic testIndex;
    startHoming(8'h22, 32'h3, 32'h10);
    check("velPos", VS, traj.vel);
    expectEnd(1'b0, 32'h20);
    startHoming(8'h21, 32'hffff_fffd, 32'h0);
    check("velNeg", -VS, traj.vel);
    expectEnd(1'b0, 32'hffff_fff0);
    idxEn = 1'b0;
    startHoming(8'h22, 32'h5a, 32'h0);
    expectEnd(1'b1, 32'h0);
    startHoming(8'h21, 32'hffff_ffa6, 32'h0);
    expectEnd(1'b1, 32'h0);
    idxEn = 1'b1;
    $display("index done");
  endtask
  task automatic testLimits;
    logic [7:0] m [5] = '{8'h12, 8'h11, 8'h02, 8'h01, 8'h11};
    logic [31:0] p [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hffff_ff99};
    logic [31:0] v [5] = '{VF, -VF, VF, -VF, VF};
    logic [31:0] h [5] = '{32'h6b, 32'hffff_ffa3, 32'h67, 32'hffff_ffa7,
                           32'hffff_ffa3};
    foreach (m[i]) begin
      startHoming(m[i], p[i], 32'h7);
      check("velStart", v[i], traj.vel);
      expectEnd(1'b0, h[i]);
    end
    $display("limits done");
  endtask
  task automatic testHardStop;
    logic [31:0] sw;
    stopEn = 1'b1;
    hardStopDelayMs = 16'h2;
    startHoming(8'hff, 32'h0, 32'h3);
    check("velHs", VF, traj.vel);
    for (int i = 0; i < 1000 && atCurrentLimit !== 1'b1; i++)
      @(negedge ref_clk);
    repeat (10) @(negedge ref_clk);
    objRd(16'h6041, sw);
    check("hsEarly", 32'h0, sw & 32'h3000);
    expectEnd(1'b0, 32'h35);
    stopEn = 1'b0;
    startHoming(8'hfe, 32'hffff_ffb0, 32'h0);
    expectEnd(1'b1, 32'h0);
    $display("hard stop done");
  endtask
  task automatic testBadMethod;
    startHoming(8'h13, 32'h0, 32'h0);
    expectEnd(1'b1, 32'h0);
    $display("bad method done");
  endtask

  // reset, then every scenario in turn
  initial begin
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    loadEn = 1'b0;
    testRegs();
    testMode();
    testCurrent();
    testMoveZero();
    testIndex();
    testLimits();
    testHardStop();
    testBadMethod();
    finishTest();
  end
endmodule // hsq_homing_sequencer_tb
`default_nettype wire
